// ==== pkg/lcs_pkg.sv ====
package lcs_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CLKX  = 8'h04;
  localparam logic [7:0] OFF_CVC   = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_MASK  = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;

  // interrupt status bit positions
  localparam int IRQ_W   = 2;
  localparam int IRQ_CV  = 0;
  localparam int IRQ_OVF = 1;

  // receive clock selection
  localparam int CLK_SEL_W = 3;
  localparam logic [2:0] CLK_SEL_ROUTE = 3'h0;
  localparam int DCO_STEP = 4; // dco half period per select step, sys clocks

  // window depth of the zero substitution codes
  localparam int WIN_D = 8;

  typedef enum logic [1:0] {
    CODE_NRZ  = 2'b00,
    CODE_CMI  = 2'b01,
    CODE_AMI  = 2'b10,
    CODE_HDBB = 2'b11
  } lcs_code_t;

  // transmit slot role after zero substitution
  typedef enum logic [1:0] {
    TXS_DATA,
    TXS_LEAD,
    TXS_VIOL,
    TXS_BAL
  } lcs_txrole_t;

  // control register, field positions fixed by member order (lsb last)
  typedef struct packed {
    logic [2:0] rx_clock_source_sel;
    logic       cmi_post_hdb3;
    logic       term_port_en;
    logic       termination_switch_bit;
    logic       e1_mode;
    logic       extended_violation_sel;
    logic       input_type_sel;
    logic       tx_dual_rail_en;
    logic       rx_dual_rail_en;
    lcs_code_t  tx_code_select;
    lcs_code_t  rx_code_select;
  } lcs_ctrl_t;

  localparam lcs_ctrl_t CTRL_RST = '0;

  // one received symbol: raw rails, decoded mark, error
  typedef struct packed {
    logic rp;
    logic rn;
    logic mark;
    logic err;
  } lcs_rslot_t;

  typedef struct packed {
    logic        d;
    lcs_txrole_t role;
  } lcs_tslot_t;

endpackage

// ==== verilog/lcs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcs_sync
  import lcs_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // second stage is the only reader of the first
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule // lcs_sync
`default_nettype wire

// ==== verilog/lcs_cv_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcs_cv_counter
  import lcs_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic         i_inc,
  input  wire logic         i_clr,
  output logic      [W-1:0] o_count,
  output logic              o_wrap
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // an error in the clearing cycle still counts, so nothing is lost
  always_comb begin
    cnt_next = i_clr ? W'(i_inc) : cnt_reg + W'(i_inc);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_count = cnt_reg;
  assign o_wrap  = i_inc && !i_clr && (&cnt_reg);

endmodule // lcs_cv_counter
`default_nettype wire

// ==== verilog/lcs_line_code.sv ====
// How it works
// - two-bit code select per direction, independent
// - rail select bit per direction: single/dual
// - single-rail rx outputs depend on line code
// - tx framer inputs mapped per code and rail
// - input type picks ternary or optical CMI
// - E1 uses HDB3/AMI, T1 uses B8ZS/AMI
// - CMI decode, HDB3/AMI after, recovered clock
// - CMI decoder passes errors, corrects nothing
// - HDB3 double or extended violation detection
// - AMI flags every bipolar violation
// - each code error bumps 16-bit counter
// - rx clock from route clock or oscillator
// - eight clock pins each pick any channel clock
// - termination switch off after reset
// - port set: switch is pin XNOR bit
// - switch closes when effective control is one
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lcs_line_code
  import lcs_pkg::*;
#(
  parameter int CV_W  = 16,
  parameter int N_CLK = 8
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_srst,
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [DATA_W-1:0]  o_rdata,
  output logic                    o_irq,
  input  wire logic               i_line_clk,
  input  wire logic               i_line_in_a,
  input  wire logic               i_line_in_b,
  input  wire logic               i_optical_data_in,
  input  wire logic               i_termination_ctrl_in,
  input  wire logic               i_tx_primary_in,
  input  wire logic               i_tx_secondary_in,
  input  wire logic [N_CLK-1:0]   i_chan_rx_clk,
  output logic                    o_rx_primary_out,
  output logic                    o_rx_secondary_out,
  output logic                    o_rx_route_clk,
  output logic                    o_chan_rx_clk,
  output logic      [N_CLK-1:0]   o_rx_clk_pins,
  output logic                    o_line_out_a,
  output logic                    o_line_out_b,
  output logic                    o_tx_frame_marker,
  output logic                    o_switch_pin
);

  localparam int SEL_W = $clog2(N_CLK);
  localparam int SYN_W = 7 + N_CLK;

  function automatic logic rmark(input lcs_rslot_t s);
    return s.rp | s.rn;
  endfunction

  function automatic logic [SEL_W-1:0] pin_sel(input logic [31:0] x,
                                               input int i);
    return x[i*SEL_W +: SEL_W];
  endfunction

  // ---------------- synchronised pins
  logic [SYN_W-1:0] syn;
  logic             lclk_s, in_a_s, in_b_s, opt_s, term_s, txp_s, txs_s;
  logic [N_CLK-1:0] chclk_s;

  lcs_sync #(.W(SYN_W)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_async   ({i_chan_rx_clk, i_tx_secondary_in, i_tx_primary_in,
                 i_termination_ctrl_in, i_optical_data_in, i_line_in_b,
                 i_line_in_a, i_line_clk}),
    .o_sync    (syn)
  );

  assign {chclk_s, txs_s, txp_s, term_s, opt_s, in_b_s, in_a_s, lclk_s} = syn;

  // ---------------- registers
  lcs_ctrl_t         ctrl_reg, ctrl_next;
  logic [31:0]       clkx_reg, clkx_next;
  logic [IRQ_W-1:0]  stat_reg, stat_next;
  logic [IRQ_W-1:0]  mask_reg, mask_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [CV_W-1:0]   cv_count;
  logic              cv_wrap, cv_inc, cv_clr;
  logic              lclk_d_reg, lclk_d_next;
  logic              rise, fall;
  logic              sw_reg, sw_next;

  // edge finder reads only the second synchroniser stage
  assign rise = lclk_s && !lclk_d_reg;
  assign fall = !lclk_s && lclk_d_reg;
  assign cv_clr = i_wr && (i_addr == OFF_CVC);

  // register writes, sticky status and read mux
  always_comb begin
    ctrl_next   = ctrl_reg;
    clkx_next   = clkx_reg;
    mask_next   = mask_reg;
    lclk_d_next = lclk_s;
    stat_next   = stat_reg;
    if (i_wr) begin
      unique case (i_addr)
        OFF_CTRL: ctrl_next = lcs_ctrl_t'(i_wdata[$bits(lcs_ctrl_t)-1:0]);
        OFF_CLKX: clkx_next = {8'h00, i_wdata[N_CLK*SEL_W-1:0]};
        OFF_MASK: mask_next = i_wdata[IRQ_W-1:0];
        OFF_STAT: stat_next = stat_reg & ~i_wdata[IRQ_W-1:0];
        default:  ;
      endcase
    end
    // set after clear: an event in the clearing cycle survives
    stat_next[IRQ_CV]  = stat_next[IRQ_CV] | cv_inc;
    stat_next[IRQ_OVF] = stat_next[IRQ_OVF] | cv_wrap;
    rdata_next = '0;
    if (i_rd) begin
      unique case (i_addr)
        OFF_CTRL:  rdata_next = DATA_W'(ctrl_reg);
        OFF_CLKX:  rdata_next = clkx_reg;
        OFF_CVC:   rdata_next = DATA_W'(cv_count);
        OFF_STAT:  rdata_next = DATA_W'(stat_reg);
        OFF_MASK:  rdata_next = DATA_W'(mask_reg);
        OFF_STATE: rdata_next = DATA_W'({o_chan_rx_clk, o_rx_route_clk,
                                         sw_reg});
        default:   rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_reg   <= CTRL_RST;
      clkx_reg   <= '0;
      stat_reg   <= '0;
      mask_reg   <= '0;
      rdata_reg  <= '0;
      lclk_d_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      clkx_reg   <= clkx_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      lclk_d_reg <= lclk_d_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq   = |(stat_reg & mask_reg);

  lcs_cv_counter #(.W(CV_W)) u_cvc (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_inc     (cv_inc),
    .i_clr     (cv_clr),
    .o_count   (cv_count),
    .o_wrap    (cv_wrap)
  );

  // ---------------- receive decoder
  logic [WIN_D-1:0][3:0] rwin_reg, rwin_next;
  lcs_rslot_t            ins, pop;
  logic                  cmi_mode, hdb, b8zs, rx_stb, rx_idle_edge;
  logic                  cmi_h1_reg, cmi_h1_next;
  logic                  rlastp_reg, rlastp_next, rlastv_reg, rlastv_next;
  logic                  rpri_reg, rpri_next, rsec_reg, rsec_next;
  logic                  route_reg, route_next;
  logic                  cmi_src, v, accept, zrun;

  assign cmi_mode = ctrl_reg.rx_code_select == CODE_CMI;
  // optical pin only with the optical type and CMI code
  assign cmi_src  = ctrl_reg.input_type_sel ? opt_s : in_a_s;
  // CMI bit completes on the falling edge, route clock follows it
  assign rx_stb   = cmi_mode ? fall : rise;
  assign rx_idle_edge = cmi_mode ? rise : fall;
  assign hdb  = (ctrl_reg.rx_code_select == CODE_HDBB) ||
                (cmi_mode && ctrl_reg.cmi_post_hdb3);
  assign b8zs = (ctrl_reg.rx_code_select == CODE_HDBB) &&
                !ctrl_reg.e1_mode;
  assign pop  = lcs_rslot_t'(rwin_reg[WIN_D-1]);

  always_comb begin
    rwin_next   = rwin_reg;
    cmi_h1_next = cmi_h1_reg;
    rlastp_next = rlastp_reg;
    rlastv_next = rlastv_reg;
    rpri_next   = rpri_reg;
    rsec_next   = rsec_reg;
    route_next  = route_reg;
    ins         = '0;
    v           = 1'b0;
    accept      = 1'b0;
    zrun        = 1'b0;
    cv_inc      = 1'b0;
    if (cmi_mode && rise) begin
      cmi_h1_next = cmi_src;
    end
    if (rx_idle_edge) begin
      route_next = 1'b0;
    end
    if (rx_stb) begin
      route_next = 1'b1;
      if (cmi_mode) begin
        // equal halves are a one at that level; 10 is passed as error
        ins.rp   = cmi_h1_reg && cmi_src;
        ins.rn   = !cmi_h1_reg && !cmi_src;
        ins.err  = cmi_h1_reg && !cmi_src;
      end else begin
        ins.rp   = in_a_s;
        ins.rn   = in_b_s;
      end
      ins.mark = rmark(ins);
      if (ctrl_reg.rx_code_select != CODE_NRZ) begin
        v = ins.mark && (ins.rp == rlastp_reg);
        if (ins.mark) begin
          rlastp_next = ins.rp;
        end
        if (hdb && !b8zs) begin
          accept = v && (ins.rp != rlastv_reg) &&
                   !rmark(lcs_rslot_t'(rwin_reg[0])) &&
                   !rmark(lcs_rslot_t'(rwin_reg[1]));
          zrun = !ins.mark && !rmark(lcs_rslot_t'(rwin_reg[0])) &&
                 !rmark(lcs_rslot_t'(rwin_reg[1])) &&
                 !rmark(lcs_rslot_t'(rwin_reg[2]));
          if (v) begin
            rlastv_next = ins.rp;
          end
          if (ctrl_reg.extended_violation_sel) begin
            ins.err = ins.err | (v && !accept) | zrun;
          end else begin
            ins.err = ins.err | (v && ins.rp == rlastv_reg);
          end
        end else if (b8zs) begin
          zrun = !ins.mark;
          for (int k = 0; k < WIN_D - 1; k++) begin
            zrun = zrun && !rmark(lcs_rslot_t'(rwin_reg[k]));
          end
          ins.err = v | (ctrl_reg.extended_violation_sel && zrun);
        end else begin
          ins.err = ins.err | v;
        end
      end
      rwin_next = {rwin_reg[WIN_D-2:0], 4'(ins)};
      if (accept) begin
        // B00V or 000V decodes to four zeros
        rwin_next[0][1] = 1'b0;
        rwin_next[3][1] = 1'b0;
      end
      if (b8zs && rmark(lcs_rslot_t'(rwin_next[4])) &&
          rmark(lcs_rslot_t'(rwin_next[3])) &&
          rmark(lcs_rslot_t'(rwin_next[1])) &&
          rmark(lcs_rslot_t'(rwin_next[0])) &&
          !rmark(lcs_rslot_t'(rwin_next[7])) &&
          !rmark(lcs_rslot_t'(rwin_next[6])) &&
          !rmark(lcs_rslot_t'(rwin_next[5])) &&
          !rmark(lcs_rslot_t'(rwin_next[2])) &&
          (rwin_next[4][3] != rwin_next[3][3]) &&
          (rwin_next[3][3] == rwin_next[1][3]) &&
          (rwin_next[1][3] != rwin_next[0][3])) begin
        // 000VB0VB is an eight-zero substitution, not an error
        for (int k = 0; k < WIN_D; k++) begin
          rwin_next[k][1:0] = 2'b00;
        end
      end
      // popped slot drives the framer side for one whole bit period
      cv_inc = pop.err && (ctrl_reg.rx_code_select != CODE_NRZ);
      if (ctrl_reg.rx_dual_rail_en) begin
        rpri_next = pop.rp;
        rsec_next = pop.rn;
      end else begin
        rpri_next = pop.mark;
        rsec_next = (ctrl_reg.rx_code_select == CODE_NRZ) ? 1'b0
                                                          : pop.err;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rwin_reg   <= '0;
      cmi_h1_reg <= 1'b0;
      rlastp_reg <= 1'b0;
      rlastv_reg <= 1'b0;
      rpri_reg   <= 1'b0;
      rsec_reg   <= 1'b0;
      route_reg  <= 1'b0;
    end else begin
      rwin_reg   <= rwin_next;
      cmi_h1_reg <= cmi_h1_next;
      rlastp_reg <= rlastp_next;
      rlastv_reg <= rlastv_next;
      rpri_reg   <= rpri_next;
      rsec_reg   <= rsec_next;
      route_reg  <= route_next;
    end
  end

  assign o_rx_primary_out   = rpri_reg;
  assign o_rx_secondary_out = rsec_reg;
  assign o_rx_route_clk     = route_reg;

  // ---------------- transmit encoder
  logic [WIN_D-1:0][2:0] twin_reg, twin_next;
  lcs_tslot_t            tpop;
  logic                  tlastp_reg, tlastp_next, tpar_reg, tpar_next;
  logic                  outa_reg, outa_next, outb_reg, outb_next;
  logic                  fm_reg, fm_next, tcmi_reg, tcmi_next;
  logic                  tone_reg, tone_next;
  logic                  tmark, tpol, tzero4, tzero8;

  assign tpop = lcs_tslot_t'(twin_reg[WIN_D-1]);

  always_comb begin
    twin_next   = twin_reg;
    tlastp_next = tlastp_reg;
    tpar_next   = tpar_reg;
    outa_next   = outa_reg;
    outb_next   = outb_reg;
    fm_next     = fm_reg;
    tcmi_next   = tcmi_reg;
    tone_next   = tone_reg;
    tmark       = 1'b0;
    tpol        = tlastp_reg;
    tzero4      = 1'b0;
    tzero8      = 1'b0;
    if (rise) begin
      twin_next = {twin_reg[WIN_D-2:0], txp_s, TXS_DATA};
      tzero4 = 1'b1;
      tzero8 = 1'b1;
      for (int k = 0; k < WIN_D; k++) begin
        if (k < 4) begin
          tzero4 = tzero4 && (twin_next[k] == {1'b0, TXS_DATA});
        end
        tzero8 = tzero8 && (twin_next[k] == {1'b0, TXS_DATA});
      end
      if (ctrl_reg.tx_code_select == CODE_HDBB) begin
        if (ctrl_reg.e1_mode && tzero4) begin
          twin_next[3] = {1'b0, TXS_LEAD};
          twin_next[0] = {1'b0, TXS_VIOL};
        end else if (!ctrl_reg.e1_mode && tzero8) begin
          twin_next[4] = {1'b0, TXS_VIOL};
          twin_next[3] = {1'b0, TXS_BAL};
          twin_next[1] = {1'b0, TXS_VIOL};
          twin_next[0] = {1'b0, TXS_BAL};
        end
      end
      // decide the popped pulse; a lead pulse keeps violations alternating
      unique case (tpop.role)
        TXS_DATA: tmark = tpop.d;
        TXS_LEAD: tmark = !tpar_reg;
        TXS_VIOL: tmark = 1'b1;
        TXS_BAL:  tmark = 1'b1;
      endcase
      if (tmark && tpop.role != TXS_VIOL) begin
        tpol        = !tlastp_reg;
        tlastp_next = tpol;
        tpar_next   = !tpar_reg;
      end else if (tpop.role == TXS_VIOL) begin
        tpar_next   = 1'b0;
      end
      fm_next = 1'b0;
      unique case (ctrl_reg.tx_code_select)
        CODE_NRZ: begin
          outa_next = txp_s;
          outb_next = 1'b0;
          fm_next   = txs_s;
        end
        CODE_CMI: begin
          // one alternates its level, zero is low then high
          tcmi_next = txp_s ? !tcmi_reg : tcmi_reg;
          tone_next = txp_s;
          outa_next = txp_s ? !tcmi_reg : 1'b0;
          outb_next = 1'b0;
        end
        CODE_AMI: begin
          if (ctrl_reg.tx_dual_rail_en) begin
            outa_next = txp_s;
            outb_next = txs_s;
          end else begin
            outa_next = tmark && tpol;
            outb_next = tmark && !tpol;
          end
        end
        CODE_HDBB: begin
          outa_next = tmark && tpol;
          outb_next = tmark && !tpol;
        end
      endcase
    end
    if (fall && ctrl_reg.tx_code_select == CODE_CMI) begin
      // a one holds its level, a zero always ends high
      outa_next = tone_reg ? tcmi_reg : 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      twin_reg   <= '0;
      tlastp_reg <= 1'b0;
      tpar_reg   <= 1'b0;
      outa_reg   <= 1'b0;
      outb_reg   <= 1'b0;
      fm_reg     <= 1'b0;
      tcmi_reg   <= 1'b0;
      tone_reg   <= 1'b0;
    end else begin
      twin_reg   <= twin_next;
      tlastp_reg <= tlastp_next;
      tpar_reg   <= tpar_next;
      outa_reg   <= outa_next;
      outb_reg   <= outb_next;
      fm_reg     <= fm_next;
      tcmi_reg   <= tcmi_next;
      tone_reg   <= tone_next;
    end
  end

  assign o_line_out_a      = outa_reg;
  assign o_line_out_b      = outb_reg;
  assign o_tx_frame_marker = fm_reg;

  // ---------------- clocks and termination
  logic [7:0]       dco_cnt_reg, dco_cnt_next;
  logic [7:0]       dco_half;
  logic             dco_reg, dco_next, chclk_reg, chclk_next;
  logic [N_CLK-1:0] pins_reg, pins_next;

  assign dco_half = 8'(ctrl_reg.rx_clock_source_sel) * 8'(DCO_STEP);

  always_comb begin
    dco_cnt_next = dco_cnt_reg + 8'h01;
    dco_next     = dco_reg;
    if (dco_cnt_reg + 8'h01 >= dco_half) begin
      dco_cnt_next = 8'h00;
      dco_next     = !dco_reg;
    end
    chclk_next = (ctrl_reg.rx_clock_source_sel == CLK_SEL_ROUTE) ? route_reg
                                                                 : dco_reg;
    for (int i = 0; i < N_CLK; i++) begin
      pins_next[i] = chclk_s[pin_sel(clkx_reg, i)];
    end
    // port-driven control is the equivalence of pin and bit
    sw_next = ctrl_reg.term_port_en
            ? !(term_s ^ ctrl_reg.termination_switch_bit)
            : ctrl_reg.termination_switch_bit;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dco_cnt_reg <= 8'h00;
      dco_reg     <= 1'b0;
      chclk_reg   <= 1'b0;
      pins_reg    <= '0;
      sw_reg      <= 1'b0;
    end else begin
      dco_cnt_reg <= dco_cnt_next;
      dco_reg     <= dco_next;
      chclk_reg   <= chclk_next;
      pins_reg    <= pins_next;
      sw_reg      <= sw_next;
    end
  end

  assign o_chan_rx_clk = chclk_reg;
  assign o_rx_clk_pins = pins_reg;
  assign o_switch_pin  = sw_reg;

endmodule // lcs_line_code
`default_nettype wire

// ==== tb/lcs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcs_chk
  import lcs_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_srst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_irq,
  input wire logic              i_termination_ctrl_in,
  input wire logic              o_rx_secondary_out,
  input wire logic              o_tx_frame_marker,
  input wire logic              o_switch_pin
);
  lcs_ctrl_t        ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic [6:0]       age_reg, age_next;
  logic             pin_reg, wr_ctrl, sw_exp;

  // shadow of control writes; age restarts whenever the switch cause moves
  always_comb begin
    wr_ctrl   = i_wr && (i_addr == OFF_CTRL);
    ctrl_next = wr_ctrl ? lcs_ctrl_t'(i_wdata[14:0]) : ctrl_reg;
    mask_next = (i_wr && i_addr == OFF_MASK) ? i_wdata[IRQ_W-1:0]
                                             : mask_reg;
    age_next  = (wr_ctrl || pin_reg != i_termination_ctrl_in) ? 7'h0
              : (age_reg == 7'h7f) ? age_reg : age_reg + 7'h1;
    sw_exp    = ctrl_reg.term_port_en
              ? ~(pin_reg ^ ctrl_reg.termination_switch_bit)
              : ctrl_reg.termination_switch_bit;
  end

  // registers only
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= '0;
      age_reg  <= '0;
      pin_reg  <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      age_reg  <= age_next;
      pin_reg  <= i_termination_ctrl_in;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (i_rd && i_addr > OFF_STATE |=> o_rdata == '0)
    else $error("unmapped read not zero");
  a_stat_width: assert property (i_rd && i_addr == OFF_STAT
    |=> o_rdata[DATA_W-1:IRQ_W] == '0) else $error("status upper bits set");
  a_switch_reset: assert property (disable iff (1'b0) i_srst |=> !o_switch_pin)
    else $error("switch closed after reset");
  a_switch_ctrl: assert property (age_reg > 7'd5 |-> o_switch_pin == sw_exp)
    else $error("switch level wrong");
  a_marker_zero: assert property (age_reg > 7'd12 &&
    ctrl_reg.tx_code_select != CODE_NRZ |-> !o_tx_frame_marker)
    else $error("frame marker outside nrz");
  a_nrz_second: assert property (age_reg > 7'd100 &&
    ctrl_reg.rx_code_select == CODE_NRZ && !ctrl_reg.rx_dual_rail_en
    |-> !o_rx_secondary_out) else $error("nrz secondary not low");
  a_irq_masked: assert property (mask_reg == '0 |-> !o_irq)
    else $error("irq with empty mask");
  a_flag_hold: assert property ($rose(o_rx_secondary_out)
    |-> o_rx_secondary_out[*6]) else $error("flag shorter than a bit");
endmodule // lcs_chk

bind lcs_line_code lcs_chk i_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq),
  .i_termination_ctrl_in(i_termination_ctrl_in),
  .o_rx_secondary_out(o_rx_secondary_out),
  .o_tx_frame_marker(o_tx_frame_marker), .o_switch_pin(o_switch_pin));
`default_nettype wire

// ==== tb/lcs_framer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcs_framer_model (
  input  wire logic i_line_clk,
  input  wire logic i_bit,
  input  wire logic i_mark,
  output logic      o_tx_data = 1'b0,
  output logic      o_tx_marker = 1'b0
);
  // launch on the falling line edge so data is steady when sampled
  always @(negedge i_line_clk) begin
    o_tx_data   <= i_bit;
    o_tx_marker <= i_mark;
  end
endmodule // lcs_framer_model
`default_nettype wire

// ==== tb/lcs_line_code_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module lcs_line_code_test;
  import lcs_pkg::*;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, lclk = 0, term = 0;
  logic        la = 0, tbit = 0, tmark = 0, tp, ts, irq, rpo, rso, lao;
  logic        fm, sw;
  logic [7:0]  addr = '0, chan = '0, pins;
  logic [31:0] wdata = '0, rdata, dat, dat2;
  logic [9:0]  hist = '0;
  logic [2:0]  txh = '0, mkh = '0;
  int          seed = 32'hb397, error_cnt = 0, total_checks = 0, k, r;
  int          mode = 0, sel[8];
  bit          chk_on = 0;

  always #12.5 clk = ~clk;
  always #100 lclk = ~lclk;

  lcs_line_code i_dut (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .i_line_clk(lclk), .i_line_in_a(la), .i_line_in_b(1'b0),
    .i_optical_data_in(1'b0), .i_termination_ctrl_in(term),
    .i_tx_primary_in(tp), .i_tx_secondary_in(ts), .i_chan_rx_clk(chan),
    .o_rx_primary_out(rpo), .o_rx_secondary_out(rso), .o_rx_route_clk(),
    .o_chan_rx_clk(), .o_rx_clk_pins(pins), .o_line_out_a(lao),
    .o_line_out_b(), .o_tx_frame_marker(fm), .o_switch_pin(sw));
  lcs_framer_model i_frm (.i_line_clk(lclk), .i_bit(tbit), .i_mark(tmark),
    .o_tx_data(tp), .o_tx_marker(ts));

  // far end of the line; mode 1 sends only positive marks
  always @(negedge lclk) begin
    r = $random(seed);
    la <= (mode == 1) | r[0];
    tbit <= r[1];
    tmark <= r[2];
    hist <= {hist[8:0], (mode == 1) | r[0]};
    txh <= {txh[1:0], r[1]};
    mkh <= {mkh[1:0], r[2]};
  end

  // nrz streams: rx through the window, tx straight out
  always @(posedge lclk) if (chk_on) begin
    `CHK("rx_data", hist[9], rpo)
    `CHK("tx_data", txh[2], lao)
    `CHK("marker", mkh[2], fm)
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 dat = rdata;
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    finish_test;
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    for (k = 0; k <= 'h18; k += 4) begin
      rd_reg(k[7:0]);
      // the state word carries the free-running route and channel clocks
      `CHK("reg_rst", 32'h0, (k == 'h14) ? dat & 32'hfffffff9 : dat)
    end
    `CHK("sw_rst", 1'b0, sw)
    repeat (12) @(negedge lclk);
    chk_on = 1;
    repeat (40) @(negedge lclk);
    chk_on = 0;
    // every port enable, bit and pin combination
    for (k = 0; k < 8; k++) begin
      wr_reg(OFF_CTRL, {21'h0, k[2:1], 9'h0});
      term <= k[0];
      repeat (8) @(posedge clk);
      `CHK("switch", k[2] ? ~(k[0] ^ k[1]) : k[1], sw)
    end
    repeat (3) begin
      dat = '0;
      for (k = 0; k < 8; k++) begin
        sel[k] = $random(seed) & 7;
        dat[3*k +: 3] = sel[k][2:0];
      end
      wr_reg(OFF_CLKX, dat);
      chan <= 8'($random(seed));
      repeat (8) @(posedge clk);
      for (k = 0; k < 8; k++) `CHK("pin", chan[sel[k]], pins[k])
    end
    // same-polarity marks: every bit is a violation
    wr_reg(OFF_CTRL, {28'h0, CODE_AMI, CODE_AMI});
    mode = 1;
    repeat (12) @(posedge lclk);
    `CHK("irq_mask", 1'b0, irq)
    wr_reg(OFF_MASK, 32'h1);
    rd_reg(OFF_CVC);
    dat2 = dat;
    repeat (16) @(posedge lclk);
    // same phase as the first read, so exactly 16 strobes lie between
    repeat (2) @(posedge clk);
    rd_reg(OFF_CVC);
    `CHK("cv_count", dat2 + 32'd16, dat)
    `CHK("err_flag", 1'b1, rso)
    `CHK("merged", 1'b1, rpo)
    `CHK("irq", 1'b1, irq)
    rd_reg(OFF_STAT);
    `CHK("stat", 32'h1, dat)
    mode = 0;
    wr_reg(OFF_CTRL, 32'h0);
    repeat (12) @(posedge lclk);
    wr_reg(OFF_STAT, 32'h1);
    rd_reg(OFF_STAT);
    `CHK("stat_clr", 32'h0, dat)
    `CHK("irq_clr", 1'b0, irq)
    wr_reg(OFF_CVC, 32'h0);
    rd_reg(OFF_CVC);
    `CHK("cv_clr", 32'h0, dat)
    finish_test;
  end
endmodule // lcs_line_code_test
`default_nettype wire
